// File: core/ppm_port.sv
// Standard-mode printer port: data, status and control pin mapping.
// Assumes one clock, synchronous reset, plain register port.
// Functional notes
// RULE1 - Status bit 4 reads online pin
// RULE2 - Status bit 5 reads media empty
// RULE3 - Status bit 7 is inverted busy
// RULE4 - Status bit 6 reads acknowledge pin
// RULE5 - Status bit 3 reads fault pin
// RULE6 - Linefeed pin is inverse control bit 1
// RULE7 - Strobe pin is inverse control bit 0
// RULE8 - Linefeed pin optionally open-drain
// RULE9 - Printer reset pin follows control bit 2
// RULE10 - Select pin is inverse control bit 3
// RULE11 - Data lines bidirectional, direction selectable
// RULE12 - Printer holds status inputs while valid
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ppm_port
   import ppm_pkg::*;
(
   input wire logic CLK,                          // Clock, 25 MHz
   input wire logic RST,                          // Sync reset, high
   input wire logic [ppm_pkg::ADDR_W-1:0] ADDR,   // Register address
   input wire logic [ppm_pkg::DATA_W-1:0] WDATA,  // Write data
   input wire logic WR,                           // Write strobe
   input wire logic RD,                           // Read strobe
   output logic [ppm_pkg::DATA_W-1:0] RDATA,      // Read data, next cycle
   input wire logic [7:0] PORT_DATA_LINES_I,      // Data lines in
   output logic [7:0] PORT_DATA_LINES_O,          // Data lines out
   output logic PORT_DATA_LINES_OE,               // Data lines drive
   input wire logic PRINTER_ONLINE_IN,            // Online status
   input wire logic MEDIA_EMPTY_IN,               // Out of paper
   input wire logic PRINTER_BUSY_IN,              // Not ready
   input wire logic PRINTER_ACCEPTED_N,           // Acknowledge, low
   input wire logic PRINTER_FAULT_N,              // Fault, low
   output logic AUTO_LINEFEED_N_O,                // Linefeed out
   output logic AUTO_LINEFEED_N_OE,               // Linefeed drive
   output logic DATA_LATCH_PULSE_N,               // Strobe, low
   output logic PRINTER_RESET_N,                  // Printer init, low
   output logic PRINTER_SELECT_N                  // Select, low
);
   import ppm_pkg::*;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] ctrl;
      logic [7:0] cfg;
      logic [7:0] rdata;
   } ppm_state_s;

   ppm_state_s st_r, st_nxt;
   ppm_sync_if sif ();
   logic [7:0] pd_in;
   logic online_s, empty_s, busy_s, accept_s, fault_s;
   logic [7:0] status_v;

   assign sif.raw = {PRINTER_FAULT_N, PRINTER_ACCEPTED_N, PRINTER_BUSY_IN,
                     MEDIA_EMPTY_IN, PRINTER_ONLINE_IN, PORT_DATA_LINES_I};

   ppm_sync u_sync (
      .CLK (CLK),
      .RST (RST),
      .sif (sif)
   );

   // Printer holds these levels while true, so a synced sample is current [RULE12]
   assign pd_in = sif.synced[7:0];
   assign online_s = sif.synced[8];
   assign empty_s = sif.synced[9];
   assign busy_s = sif.synced[10];
   assign accept_s = sif.synced[11];
   assign fault_s = sif.synced[12];

   always_comb begin
      status_v = ZERO_BYTE;
      status_v[STS_FAULT] = fault_s;   // [RULE5]
      status_v[STS_ONLINE] = online_s; // [RULE1]
      status_v[STS_EMPTY] = empty_s;   // [RULE2]
      status_v[STS_ACCEPT] = accept_s; // [RULE4]
      status_v[STS_READY] = ~busy_s;   // [RULE3]
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = ZERO_BYTE;
      if (WR) begin
         unique case (ADDR)
            REG_DATA: st_nxt.data = WDATA;
            REG_CONTROL: st_nxt.ctrl = WDATA;
            REG_CONFIG: st_nxt.cfg = WDATA;
            default: ;
         endcase
      end
      if (RD) begin
         unique case (ADDR)
            // Input direction returns the pins, output returns the latch [RULE11]
            REG_DATA: st_nxt.rdata = st_r.ctrl[CTL_DIR] ? pd_in : st_r.data;
            REG_STATUS: st_nxt.rdata = status_v;
            REG_CONTROL: st_nxt.rdata = st_r.ctrl;
            REG_CONFIG: st_nxt.rdata = st_r.cfg;
            default: st_nxt.rdata = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_r.data <= DATA_RST;
         st_r.ctrl <= CONTROL_RST;
         st_r.cfg <= CONFIG_RST;
         st_r.rdata <= ZERO_BYTE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RDATA = st_r.rdata;
   assign PORT_DATA_LINES_O = st_r.data;                 // [RULE11]
   assign PORT_DATA_LINES_OE = ~st_r.ctrl[CTL_DIR];      // [RULE11]
   assign DATA_LATCH_PULSE_N = ~st_r.ctrl[CTL_LATCH];    // [RULE7]
   assign PRINTER_RESET_N = st_r.ctrl[CTL_RESET];        // [RULE9]
   assign PRINTER_SELECT_N = ~st_r.ctrl[CTL_SELECT];     // [RULE10]
   // Open-drain: drive only the low level [RULE8]
   assign AUTO_LINEFEED_N_O = ~st_r.ctrl[CTL_LINEFEED];  // [RULE6]
   assign AUTO_LINEFEED_N_OE = st_r.cfg[CFG_ALF_OD] ? st_r.ctrl[CTL_LINEFEED] : 1'b1; // [RULE8]
endmodule // ppm_port
`default_nettype wire

// File: core/ppm_pkg.sv
// Package for the printer port pin mapping block.
// Assumes a single 25 MHz clock and a plain register port.
package ppm_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [2:0] REG_DATA = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_CONTROL = 3'h2;
   localparam logic [2:0] REG_CONFIG = 3'h3;
   // Status register bit positions
   localparam int STS_FAULT = 3;
   localparam int STS_ONLINE = 4;
   localparam int STS_EMPTY = 5;
   localparam int STS_ACCEPT = 6;
   localparam int STS_READY = 7;
   // Control register bit positions
   localparam int CTL_LATCH = 0;
   localparam int CTL_LINEFEED = 1;
   localparam int CTL_RESET = 2;
   localparam int CTL_SELECT = 3;
   localparam int CTL_DIR = 5;
   // Config register bit positions
   localparam int CFG_ALF_OD = 0;
   // Reset values
   localparam logic [7:0] CONTROL_RST = 8'h04;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : ppm_pkg

// File: core/ppm_sync_if.sv
// Interface carrying raw and synchronised printer inputs.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ppm_sync_if;
   logic [12:0] raw;
   logic [12:0] synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface : ppm_sync_if
`default_nettype wire

// File: core/ppm_sync.sv
// Two-flop synchroniser for the printer-side inputs.
// Assumes inputs are asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module ppm_sync (
   input wire logic CLK,  // Clock
   input wire logic RST,  // Sync reset
   ppm_sync_if.sync sif   // Raw in, synced out
);
   typedef struct packed {
      logic [12:0] s1;
      logic [12:0] s2;
   } ppm_sync_s;
   ppm_sync_s st_r, st_nxt;
   always_comb begin
      st_nxt.s1 = sif.raw;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign sif.synced = st_r.s2;
endmodule // ppm_sync
`default_nettype wire

// File: verif/ppm_port_sva.sv
// Checker for the printer port pin mapping.
// Bound to ppm_port; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_sva (
   input wire logic CLK, // Clock
   input wire logic RST, // Reset
   input wire logic [2:0] ADDR, // Address
   input wire logic [7:0] WDATA, // Write data
   input wire logic WR, // Write
   input wire logic RD, // Read
   input wire logic [7:0] RDATA, // Read data
   input wire logic PRINTER_ONLINE_IN, // Online
   input wire logic MEDIA_EMPTY_IN, // Paper out
   input wire logic PRINTER_BUSY_IN, // Not ready
   input wire logic PRINTER_ACCEPTED_N, // Acknowledge
   input wire logic PRINTER_FAULT_N, // Fault
   input wire logic AUTO_LINEFEED_N_O, // Linefeed
   input wire logic DATA_LATCH_PULSE_N, // Strobe
   input wire logic PRINTER_RESET_N, // Printer init
   input wire logic PRINTER_SELECT_N, // Select
   input wire logic AUTO_LINEFEED_N_OE, // Linefeed drive
   input wire logic PORT_DATA_LINES_OE // Data lines drive
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   wire logic [4:0] st = {PRINTER_BUSY_IN, PRINTER_ACCEPTED_N, MEDIA_EMPTY_IN, PRINTER_ONLINE_IN, PRINTER_FAULT_N};
   sequence calm; $stable(st)[*4] ##0 (RD && ADDR == 3'h1); endsequence
   online_bit_a: assert property (calm |=> RDATA[4] == $past(st[1])) else $error("Online bit wrong");
   empty_bit_a: assert property (calm |=> RDATA[5] == $past(st[2])) else $error("Empty bit wrong");
   ready_bit_a: assert property (calm |=> RDATA[7] != $past(st[4])) else $error("Ready bit wrong");
   accept_bit_a: assert property (calm |=> RDATA[6] == $past(st[3])) else $error("Accept bit wrong");
   fault_bit_a: assert property (calm |=> RDATA[3] == $past(st[0])) else $error("Fault bit wrong");
   linefeed_pin_a: assert property (WR && ADDR == 3'h2 |=> AUTO_LINEFEED_N_O != $past(WDATA[1]))
      else $error("Linefeed pin wrong");
   latch_pin_a: assert property (WR && ADDR == 3'h2 |=> DATA_LATCH_PULSE_N != $past(WDATA[0]))
      else $error("Strobe pin wrong");
   reset_pin_a: assert property (WR && ADDR == 3'h2 |=> PRINTER_RESET_N == $past(WDATA[2]))
      else $error("Reset pin wrong");
   select_pin_a: assert property (WR && ADDR == 3'h2 |=> PRINTER_SELECT_N != $past(WDATA[3]))
      else $error("Select pin wrong");
   data_drive_a: assert property (WR && ADDR == 3'h2 |=> PORT_DATA_LINES_OE != $past(WDATA[5]))
      else $error("Data drive wrong");
   linefeed_low_a: assert property (AUTO_LINEFEED_N_OE || AUTO_LINEFEED_N_O)
      else $error("Linefeed low undriven");
endmodule // ppm_port_sva
bind ppm_port ppm_port_sva chk (
   .CLK (CLK),
   .RST (RST),
   .ADDR (ADDR),
   .WDATA (WDATA),
   .WR (WR),
   .RD (RD),
   .RDATA (RDATA),
   .PRINTER_ONLINE_IN (PRINTER_ONLINE_IN),
   .MEDIA_EMPTY_IN (MEDIA_EMPTY_IN),
   .PRINTER_BUSY_IN (PRINTER_BUSY_IN),
   .PRINTER_ACCEPTED_N (PRINTER_ACCEPTED_N),
   .PRINTER_FAULT_N (PRINTER_FAULT_N),
   .AUTO_LINEFEED_N_O (AUTO_LINEFEED_N_O),
   .DATA_LATCH_PULSE_N (DATA_LATCH_PULSE_N),
   .PRINTER_RESET_N (PRINTER_RESET_N),
   .PRINTER_SELECT_N (PRINTER_SELECT_N),
   .AUTO_LINEFEED_N_OE (AUTO_LINEFEED_N_OE),
   .PORT_DATA_LINES_OE (PORT_DATA_LINES_OE)
);
`default_nettype wire

// File: verif/ppm_printer.sv
// Printer model: status levels and data pin driver.
// Assumes the bench supplies the levels to present.
`timescale 1ns/1ps
`default_nettype none
module ppm_printer (
   input wire logic [12:0] want, // Levels to present
   input wire logic oe, // Port drives data
   input wire logic [7:0] o, // Port data out
   output logic [7:0] pins, // Resolved data lines
   output logic [4:0] st // Status levels
);
   assign pins = oe ? o : want[7:0];
   assign st = want[12:8];
endmodule // ppm_printer
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the printer port pin mapping.
// Assumes the printer model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic CLK = 0, RST = 1, WR = 0, RD = 0;
   logic [2:0] ADDR = 0;
   logic [7:0] WDATA = 0, rdata, pins, po, e;
   logic [12:0] want = 0;
   logic [4:0] st;
   logic poe, lo, loe, stb, rn, sn;
   logic [31:0] x = 32'hFF72FA45;
   int bad_count = 0, checked = 0, c, g, d;
   always #20 CLK = ~CLK;
   ppm_printer prn (.want(want), .oe(poe), .o(po), .pins(pins), .st(st));
   ppm_port uut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(rdata),
      .PORT_DATA_LINES_I(pins), .PORT_DATA_LINES_O(po), .PORT_DATA_LINES_OE(poe), .PRINTER_ONLINE_IN(st[1]),
      .MEDIA_EMPTY_IN(st[2]), .PRINTER_BUSY_IN(st[4]), .PRINTER_ACCEPTED_N(st[3]), .PRINTER_FAULT_N(st[0]),
      .AUTO_LINEFEED_N_O(lo), .AUTO_LINEFEED_N_OE(loe), .DATA_LATCH_PULSE_N(stb), .PRINTER_RESET_N(rn),
      .PRINTER_SELECT_N(sn));
   function automatic logic [31:0] rnd(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      return v ^ (v << 5);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge CLK) {WR, ADDR, WDATA} <= {1'b1, a, v};
      @(posedge CLK) WR <= 0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge CLK) {RD, ADDR} <= {1'b1, a};
      @(posedge CLK) RD <= 0;
      #1 chk(rdata, exp);
   endtask
   task automatic pinchk();
      chk({lo, loe}, {~c[1], c[1] | ~g[0]});
      chk({poe, stb, rn, sn}, {~c[5], ~c[0], c[2], ~c[3]});
   endtask
   task automatic summarize();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #80000;
      bad_count++;
      summarize();
   end
   initial begin
      c = 8'h04;
      g = 0;
      repeat (4) @(posedge CLK);
      RST <= 0;
      #1 pinchk();
      rd(3'h2, 8'h04);
      for (int i = 0; i < 24; i++) begin
         x = rnd(x);
         @(posedge CLK) want <= x[12:0];
         c = x[20:13] & 8'h2F;
         g = x[21];
         d = x[29:22];
         wr(3'h2, c);
         wr(3'h3, g);
         wr(3'h0, d);
         wr(3'h1, 8'hFF);
         repeat (4) @(posedge CLK);
         pinchk();
         if (!c[5]) chk(po, d);
         e = {~want[12], want[11:8], 3'h0};
         rd(3'h1, e);
         rd(3'h0, c[5] ? want[7:0] : d);
         rd(3'h2, c);
         rd(3'h3, g);
         rd(3'h5, 8'h00);
      end
      // Mid-run reset must restore pin levels and registers
      @(posedge CLK) RST <= 1;
      repeat (2) @(posedge CLK);
      RST <= 0;
      c = 8'h04;
      g = 0;
      #1 pinchk();
      rd(3'h0, 8'h00);
      rd(3'h3, 8'h00);
      summarize();
   end
endmodule // testbench
`default_nettype wire
